/* rtl/tmc_pkg.sv */
package tmc_pkg;

  // register map
  localparam logic [7:0] CTRL_ADDR      = 8'hc8;
  localparam logic [7:0] AUX_ADDR       = 8'hc9;
  localparam logic [7:0] RELOAD_LO_ADDR = 8'hca;
  localparam logic [7:0] RELOAD_HI_ADDR = 8'hcb;
  localparam logic [7:0] COUNT_LO_ADDR  = 8'hcc;
  localparam logic [7:0] COUNT_HI_ADDR  = 8'hcd;

  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  AUX_RESET    = 8'h00;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [7:0]  READ_IDLE    = 8'h00;

  // clk is the oscillator; a machine cycle is twelve oscillator periods
  localparam int CLK_NS      = 50;
  localparam int MC_OSC      = 12;
  localparam int MC_NS       = MC_OSC * CLK_NS;
  localparam int MC_CYCLES   = (MC_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] MC_LAST  = 4'(MC_CYCLES - 1);
  localparam logic [3:0] MC_FIRST = 4'h0;

  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic receive_baud_select;
    logic transmit_baud_select;
    logic external_trigger_enable;
    logic run_control;
    logic count_source_select;
    logic capture_not_reload;
  } tmc_ctrl_type;

  typedef struct packed {
    logic [5:0] reserved;
    logic       clock_out_enable;
    logic       down_count_enable;
  } tmc_aux_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmc_bus_req_type;

  typedef enum logic [2:0] {
    TMC_OFF     = 3'h0,
    TMC_RELOAD  = 3'h1,
    TMC_CAPTURE = 3'h3,
    TMC_BAUD    = 3'h2,
    TMC_CLKOUT  = 3'h6
  } tmc_mode_type;

  typedef struct packed {
    tmc_ctrl_type ctrl;
    tmc_aux_type  aux;
    logic [15:0]  count;
    logic [15:0]  reload;
    logic [3:0]   mc;
    logic         half;
    logic         cnt_s1;
    logic         cnt_s2;
    logic         cnt_prev;
    logic         trig_s1;
    logic         trig_s2;
    logic         trig_prev;
    logic [7:0]   rdata;
    logic         irq;
    logic         rx_tick;
    logic         tx_tick;
    logic         clk_out;
    logic         clk_oe;
  } tmc_state_type;

endpackage : tmc_pkg

/* rtl/tmc_timer.sv */
`timescale 1ns/1ns
module tmc_timer (
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire tmc_pkg::tmc_bus_req_type bus_req,
  output logic [7:0]                    rdata,
  input  wire logic                     count_pin,
  input  wire logic                     trigger_pin,
  input  wire logic                     other_timer_overflow,
  output logic                          timer_irq,
  output logic                          rx_baud_tick,
  output logic                          tx_baud_tick,
  output logic                          clock_out,
  output logic                          clock_out_oe
);

  tmc_pkg::tmc_state_type s;
  tmc_pkg::tmc_state_type next_s;
  tmc_pkg::tmc_mode_type  mode;
  logic                   mc_end;
  logic                   baud;
  logic                   clk_mode;
  logic                   cnt_fall;
  logic                   trig_fall;
  logic                   tick;
  logic                   ovf;
  logic                   trig_evt;
  logic                   reload_now;
  logic                   ctrl_wr;
  logic                   count_wr;
  logic                   reload_wr;

  assign ctrl_wr   = bus_req.wr && bus_req.addr == tmc_pkg::CTRL_ADDR;
  assign count_wr  = bus_req.wr && (bus_req.addr == tmc_pkg::COUNT_LO_ADDR ||
                                    bus_req.addr == tmc_pkg::COUNT_HI_ADDR);
  assign reload_wr = bus_req.wr && (bus_req.addr == tmc_pkg::RELOAD_LO_ADDR ||
                                    bus_req.addr == tmc_pkg::RELOAD_HI_ADDR);

  always_comb begin
    next_s   = s;
    baud     = s.ctrl.receive_baud_select | s.ctrl.transmit_baud_select;
    clk_mode = s.aux.clock_out_enable & ~s.ctrl.capture_not_reload;
    if (!s.ctrl.run_control) begin
      mode = tmc_pkg::TMC_OFF;
    end else if (baud) begin
      mode = tmc_pkg::TMC_BAUD;
    end else if (clk_mode) begin
      mode = tmc_pkg::TMC_CLKOUT;
    end else if (s.ctrl.capture_not_reload) begin
      mode = tmc_pkg::TMC_CAPTURE;
    end else begin
      mode = tmc_pkg::TMC_RELOAD;
    end
    // machine cycle time base
    mc_end  = s.mc == tmc_pkg::MC_LAST;
    next_s.mc   = mc_end ? tmc_pkg::MC_FIRST : 4'(s.mc + 4'h1);
    next_s.half = ~s.half;
    // first stage feeds only the second
    next_s.cnt_s1  = count_pin;
    next_s.cnt_s2  = s.cnt_s1;
    next_s.trig_s1 = trigger_pin;
    next_s.trig_s2 = s.trig_s1;
    if (mc_end) begin
      next_s.cnt_prev  = s.cnt_s2;
      next_s.trig_prev = s.trig_s2;
    end
    cnt_fall  = mc_end & s.cnt_prev & ~s.cnt_s2;
    trig_fall = mc_end & s.trig_prev & ~s.trig_s2;
    // counter pin is never counted in clock-out mode, and is an output there only while count_source_select is clear
    if (mode == tmc_pkg::TMC_OFF) begin
      tick = 1'b0;
    end else if (s.ctrl.count_source_select && !clk_mode) begin
      tick = cnt_fall;
    end else if (mode == tmc_pkg::TMC_BAUD || mode == tmc_pkg::TMC_CLKOUT) begin
      tick = s.half;
    end else begin
      tick = mc_end;
    end
    ovf      = tick & (s.count == tmc_pkg::COUNT_MAX);
    trig_evt = trig_fall & s.ctrl.external_trigger_enable & ~baud;
    reload_now = (ovf & (baud | ~s.ctrl.capture_not_reload))
               | (trig_evt & ~s.ctrl.capture_not_reload);
    // software writes
    if (ctrl_wr) begin
      next_s.ctrl = tmc_pkg::tmc_ctrl_type'(bus_req.wdata);
    end
    if (bus_req.wr && bus_req.addr == tmc_pkg::AUX_ADDR) begin
      next_s.aux = tmc_pkg::tmc_aux_type'({6'h00, bus_req.wdata[1:0]});
    end
    // count: reload beats increment, overflow leaves plain wrap in capture mode
    if (reload_now) begin
      next_s.count = s.reload;
    end else if (tick) begin
      next_s.count = 16'(s.count + 16'h0001);
    end
    if (bus_req.wr && bus_req.addr == tmc_pkg::COUNT_LO_ADDR) begin
      next_s.count[7:0] = bus_req.wdata;
    end
    if (bus_req.wr && bus_req.addr == tmc_pkg::COUNT_HI_ADDR) begin
      next_s.count[15:8] = bus_req.wdata;
    end
    if (bus_req.wr && bus_req.addr == tmc_pkg::RELOAD_LO_ADDR) begin
      next_s.reload[7:0] = bus_req.wdata;
    end
    if (bus_req.wr && bus_req.addr == tmc_pkg::RELOAD_HI_ADDR) begin
      next_s.reload[15:8] = bus_req.wdata;
    end
    // hardware capture wins over a same-cycle software write
    if (trig_evt && s.ctrl.capture_not_reload) begin
      next_s.reload = s.count;
    end
    // flag sets win over software clears
    if (ovf && !baud) begin
      next_s.ctrl.overflow_flag = 1'b1;
    end
    if (trig_evt) begin
      next_s.ctrl.external_event_flag = 1'b1;
    end
    next_s.irq = s.ctrl.overflow_flag
               | (s.ctrl.external_event_flag & ~s.aux.down_count_enable);
    next_s.rx_tick = s.ctrl.receive_baud_select ? ovf : other_timer_overflow;
    next_s.tx_tick = s.ctrl.transmit_baud_select ? ovf : other_timer_overflow;
    next_s.clk_oe  = clk_mode & ~s.ctrl.count_source_select;
    if (ovf && mode == tmc_pkg::TMC_CLKOUT) begin
      next_s.clk_out = ~s.clk_out;
    end
    // read port, idle value outside the answer cycle
    next_s.rdata = tmc_pkg::READ_IDLE;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        tmc_pkg::CTRL_ADDR:      next_s.rdata = s.ctrl;
        tmc_pkg::AUX_ADDR:       next_s.rdata = s.aux;
        tmc_pkg::RELOAD_LO_ADDR: next_s.rdata = s.reload[7:0];
        tmc_pkg::RELOAD_HI_ADDR: next_s.rdata = s.reload[15:8];
        tmc_pkg::COUNT_LO_ADDR:  next_s.rdata = s.count[7:0];
        tmc_pkg::COUNT_HI_ADDR:  next_s.rdata = s.count[15:8];
        default:                 next_s.rdata = tmc_pkg::READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s        <= '0;
      s.ctrl   <= tmc_pkg::CTRL_RESET;
      s.aux    <= tmc_pkg::AUX_RESET;
      s.count  <= tmc_pkg::COUNT_RESET;
      s.reload <= tmc_pkg::RELOAD_RESET;
      s.mc     <= tmc_pkg::MC_FIRST;
      s.rdata  <= tmc_pkg::READ_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign rdata        = s.rdata;
  assign timer_irq    = s.irq;
  assign rx_baud_tick = s.rx_tick;
  assign tx_baud_tick = s.tx_tick;
  assign clock_out    = s.clk_out;
  assign clock_out_oe = s.clk_oe;

  chk_ovf_sets_flag: assert property (@(posedge clk) disable iff (!resetn)
    ovf && !baud |=> s.ctrl.overflow_flag ##1 timer_irq)
    else $error("overflow did not set flag and interrupt");

  chk_baud_no_flag: assert property (@(posedge clk) disable iff (!resetn)
    baud && !s.ctrl.overflow_flag && !ctrl_wr |=> !s.ctrl.overflow_flag)
    else $error("overflow flag set in baud mode");

  chk_trig_sets_event: assert property (@(posedge clk) disable iff (!resetn)
    trig_evt |=> s.ctrl.external_event_flag)
    else $error("trigger edge did not set event flag");

  chk_event_irq: assert property (@(posedge clk) disable iff (!resetn)
    s.ctrl.external_event_flag && !s.aux.down_count_enable |=> timer_irq)
    else $error("event flag raised no interrupt");

  chk_rx_route: assert property (@(posedge clk) disable iff (!resetn)
    s.ctrl.receive_baud_select && ovf && !ctrl_wr |=> rx_baud_tick ##1 !rx_baud_tick)
    else $error("receive clock not fed by overflow");

  chk_tx_route: assert property (@(posedge clk) disable iff (!resetn)
    !s.ctrl.transmit_baud_select |=> tx_baud_tick == $past(other_timer_overflow))
    else $error("transmit clock not fed by other timer");

  chk_baud_ignores_trig: assert property (@(posedge clk) disable iff (!resetn)
    trig_fall && baud && !s.ctrl.external_event_flag && !ctrl_wr
    |=> !s.ctrl.external_event_flag)
    else $error("trigger acted in baud mode");

  chk_timer_rate: assert property (@(posedge clk) disable iff (!resetn)
    mode == tmc_pkg::TMC_RELOAD && !s.ctrl.count_source_select && tick
    |=> !tick [*8])
    else $error("timer ticked faster than a machine cycle");

  chk_capture_copy: assert property (@(posedge clk) disable iff (!resetn)
    trig_evt && s.ctrl.capture_not_reload |=> s.reload == $past(s.count))
    else $error("capture did not copy count");

  chk_reload_load: assert property (@(posedge clk) disable iff (!resetn)
    reload_now && !count_wr |=> s.count == $past(s.reload))
    else $error("reload did not load count");

  // same-cycle software writes win by design except over capture and flag sets, so most checks step around them
  chk_reload_hold: assert property (@(posedge clk) disable iff (!resetn)
    !reload_wr && !(trig_evt && s.ctrl.capture_not_reload) |=> $stable(s.reload))
    else $error("reload bytes changed without write or capture");

  chk_count_step: assert property (@(posedge clk) disable iff (!resetn)
    tick && !reload_now && !count_wr |=> s.count == 16'($past(s.count) + 16'h0001))
    else $error("count did not advance by one");

  chk_off_holds: assert property (@(posedge clk) disable iff (!resetn)
    mode == tmc_pkg::TMC_OFF && !reload_now && !count_wr |=> $stable(s.count))
    else $error("count moved while timer off");

  chk_clkout_toggle: assert property (@(posedge clk) disable iff (!resetn)
    ovf && mode == tmc_pkg::TMC_CLKOUT |=> clock_out != $past(clock_out))
    else $error("clock-out did not toggle on overflow");

  chk_oe_needs_enable: assert property (@(posedge clk) disable iff (!resetn)
    !s.aux.clock_out_enable |=> !clock_out_oe)
    else $error("count pin driven without clock-out enable");

  chk_irq_masked: assert property (@(posedge clk) disable iff (!resetn)
    !s.ctrl.overflow_flag && s.aux.down_count_enable |=> !timer_irq)
    else $error("masked event flag raised interrupt");

  chk_rx_other: assert property (@(posedge clk) disable iff (!resetn)
    !s.ctrl.receive_baud_select |=> rx_baud_tick == $past(other_timer_overflow))
    else $error("receive clock not fed by other timer");

  chk_tx_own: assert property (@(posedge clk) disable iff (!resetn)
    s.ctrl.transmit_baud_select && ovf |=> tx_baud_tick)
    else $error("transmit clock not fed by overflow");

  chk_trig_disabled: assert property (@(posedge clk) disable iff (!resetn)
    trig_fall && !s.ctrl.external_trigger_enable && !ctrl_wr
    |=> $stable(s.ctrl.external_event_flag))
    else $error("disabled trigger edge changed event flag");

  chk_baud_rate: assert property (@(posedge clk) disable iff (!resetn)
    mode == tmc_pkg::TMC_BAUD && !s.ctrl.count_source_select && !ctrl_wr
    |=> tick != $past(tick))
    else $error("baud generator not ticking every other clock");

  chk_capture_keeps_count: assert property (@(posedge clk) disable iff (!resetn)
    trig_evt && s.ctrl.capture_not_reload && !tick && !count_wr
    |=> $stable(s.count))
    else $error("capture disturbed the count");

  chk_trig_reload: assert property (@(posedge clk) disable iff (!resetn)
    trig_evt && !s.ctrl.capture_not_reload && !count_wr |=> s.count == $past(s.reload))
    else $error("trigger edge did not reload count");

  chk_baud_reload: assert property (@(posedge clk) disable iff (!resetn)
    ovf && baud && s.ctrl.capture_not_reload && !count_wr |=> s.count == $past(s.reload))
    else $error("baud mode did not reload on overflow");

  chk_capture_wraps: assert property (@(posedge clk) disable iff (!resetn)
    ovf && mode == tmc_pkg::TMC_CAPTURE && !count_wr |=> s.count == '0)
    else $error("capture mode overflow did not wrap");

  chk_ctrl_readback: assert property (@(posedge clk) disable iff (!resetn)
    bus_req.rd && bus_req.addr == tmc_pkg::CTRL_ADDR |=> rdata == $past(s.ctrl))
    else $error("control register read back wrong");

  chk_count_on_edge: assert property (@(posedge clk) disable iff (!resetn)
    s.ctrl.count_source_select && !clk_mode && tick |-> cnt_fall && mc_end)
    else $error("counter ticked without a sampled pin edge");

  chk_edge_spacing: assert property (@(posedge clk) disable iff (!resetn)
    trig_fall |=> !trig_fall [*8])
    else $error("trigger edges closer than a machine cycle");

  cov_capture:  cover property (@(posedge clk) disable iff (!resetn)
    trig_evt && s.ctrl.capture_not_reload);
  cov_ovf_reload: cover property (@(posedge clk) disable iff (!resetn)
    ovf && mode == tmc_pkg::TMC_RELOAD);
  cov_baud_tick: cover property (@(posedge clk) disable iff (!resetn)
    ovf && mode == tmc_pkg::TMC_BAUD);
  cov_clkout: cover property (@(posedge clk) disable iff (!resetn)
    ovf && mode == tmc_pkg::TMC_CLKOUT);
  cov_trig_reload: cover property (@(posedge clk) disable iff (!resetn)
    trig_evt && !s.ctrl.capture_not_reload);

endmodule : tmc_timer

/* tb/tmc_far_side.sv */
`timescale 1ns/1ns
module tmc_far_side (
  input  wire logic clk,
  input  wire logic rx_baud_tick,
  input  wire logic tx_baud_tick,
  output logic      trigger_pin,
  output logic      count_pin,
  output logic      other_timer_overflow
);
  int         rx_n = 0;
  int         tx_n = 0;
  int         ov_n = 0;
  logic [2:0] div = 3'h0;
  initial begin
    trigger_pin = 1'b1;
    count_pin = 1'b1;
    other_timer_overflow = 1'b0;
  end
  // other timer overflows every 8 clocks, apart from any baud rate under test
  always @(posedge clk) begin
    div <= div + 3'h1;
    other_timer_overflow <= (div == 3'h7);
    ov_n <= ov_n + int'(div == 3'h7);
    rx_n <= rx_n + int'(rx_baud_tick === 1'b1);
    tx_n <= tx_n + int'(tx_baud_tick === 1'b1);
  end
  // each level held two machine cycles so one sample of each is certain
  task automatic fall(input logic trig, input int n);
    repeat (n) begin
      @(posedge clk);
      if (trig) trigger_pin <= 1'b0; else count_pin <= 1'b0;
      repeat (24) @(posedge clk);
      if (trig) trigger_pin <= 1'b1; else count_pin <= 1'b1;
      repeat (24) @(posedge clk);
    end
  endtask : fall
endmodule : tmc_far_side

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic                     clk;
  logic                     resetn;
  tmc_pkg::tmc_bus_req_type req;
  logic [7:0]               rdata;
  logic                     trig, cpin, oth, irq, rxt, txt, cko, ckoe;
  logic [7:0]               exp_q[$];
  int                       n_mismatch = 0;
  int                       samples_checked = 0;
  logic [31:0]              seed = 32'h0000003a;
  logic [7:0]               rv;
  logic                     pend = 1'b0;
  logic                     cko_d = 1'b0;
  int                       ck_n = 0;
  int                       r0, t0, i;

  tmc_timer u_dut (.clk(clk), .resetn(resetn), .bus_req(req), .rdata(rdata),
    .count_pin(cpin), .trigger_pin(trig), .other_timer_overflow(oth), .timer_irq(irq),
    .rx_baud_tick(rxt), .tx_baud_tick(txt), .clock_out(cko), .clock_out_oe(ckoe));
  tmc_far_side u_far (.clk(clk), .rx_baud_tick(rxt), .tx_baud_tick(txt),
    .trigger_pin(trig), .count_pin(cpin), .other_timer_overflow(oth));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : xs

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // tick counts may straddle the window edges by one
  task automatic near(input int got, input int exp);
    cmp({7'h0, got >= exp - 1 && got <= exp + 1}, 8'h01);
  endtask : near

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(exp);
    @(posedge clk);
    req.rd <= 1'b0;
  endtask : rd

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (pend) cmp(rdata, exp_q.pop_front());
    pend = req.rd;
    ck_n += int'(cko !== cko_d);
    cko_d = cko;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    req = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(8'hc8, 8'h00);
    wr(8'hc9, 8'hff);
    rd(8'hc9, 8'h03);
    wr(8'hc9, 8'h00);
    rd(8'hc0, 8'h00);
    r0 = u_far.rx_n;
    t0 = u_far.ov_n;
    repeat (160) @(posedge clk);
    near(u_far.rx_n - r0, u_far.ov_n - t0);
    $display("test reset and routing done");
    // reload mode then plain capture timer, each through one overflow
    for (i = 0; i < 2; i++) begin
      rv = xs();
      wr(8'hca, 8'h00);
      wr(8'hcb, rv);
      rd(8'hcb, rv);
      wr(8'hcc, 8'hfe);
      wr(8'hcd, 8'hff);
      wr(8'hc8, 8'h04 | 8'(i));
      repeat (30) @(posedge clk);
      rd(8'hc8, 8'h84 | 8'(i));
      rd(8'hcd, (i == 0) ? rv : 8'h00);
      cmp({7'h0, irq}, 8'h01);
      wr(8'hc8, 8'h04);
      rd(8'hc8, 8'h04);
      repeat (3) @(posedge clk);
      cmp({7'h0, irq}, 8'h00);
      wr(8'hc8, 8'h00);
    end
    $display("test overflow done");
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hf0);
    wr(8'hcd, 8'hff);
    r0 = u_far.rx_n;
    t0 = u_far.tx_n;
    wr(8'hc8, 8'h35);
    repeat (320) @(posedge clk);
    rd(8'hc8, 8'h35);
    near(u_far.rx_n - r0, 10);
    near(u_far.tx_n - t0, 10);
    wr(8'hc8, 8'h00);
    $display("test baud done");
    wr(8'hcc, 8'hcd);
    wr(8'hcd, 8'hab);
    wr(8'hc8, 8'h09);
    u_far.fall(1'b1, 1);
    rd(8'hca, 8'hcd);
    rd(8'hcb, 8'hab);
    rd(8'hc8, 8'h49);
    cmp({7'h0, irq}, 8'h01);
    wr(8'hc9, 8'h01);
    repeat (3) @(posedge clk);
    cmp({7'h0, irq}, 8'h00);
    wr(8'hc9, 8'h00);
    wr(8'hca, 8'h78);
    wr(8'hcb, 8'h56);
    wr(8'hc8, 8'h08);
    u_far.fall(1'b1, 1);
    rd(8'hcc, 8'h78);
    rd(8'hcd, 8'h56);
    rd(8'hc8, 8'h48);
    // trigger disabled, then enabled but serving the serial port
    for (i = 0; i < 2; i++) begin
      rv = (i == 0) ? 8'h01 : 8'h39;
      wr(8'hc8, rv);
      u_far.fall(1'b1, 1);
      rd(8'hc8, rv);
      rd(8'hcc, 8'h78);
    end
    $display("test trigger done");
    wr(8'hcc, 8'h00);
    wr(8'hc8, 8'h06);
    u_far.fall(1'b0, 5);
    rd(8'hcc, 8'h05);
    wr(8'hc8, 8'h00);
    wr(8'hc9, 8'h02);
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hf0);
    wr(8'hcd, 8'hff);
    r0 = ck_n;
    wr(8'hc8, 8'h04);
    repeat (3) @(posedge clk);
    cmp({7'h0, ckoe}, 8'h01);
    repeat (317) @(posedge clk);
    near(ck_n - r0, 10);
    // oe follows the enable bit, not run, so drop the enable first
    wr(8'hc9, 8'h00);
    repeat (3) @(posedge clk);
    cmp({7'h0, ckoe}, 8'h00);
    wr(8'hc8, 8'h00);
    $display("test counter and clock-out done");
    // a reset in mid-run must clear a busy control register
    wr(8'hc8, 8'h3c);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'hc8, 8'h00);
    $display("test mid-run reset done");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : testbench
